// ### verilog/fault_pkg.sv
package fault_pkg;
	// ************************************************
	// bus geometry
	// ************************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int FUSE_AW = 5;
	localparam int FUSE_DEPTH = 32;

	// ************************************************
	// register offsets
	// ************************************************
	localparam logic [11:0] A_OEN_MAIN = 12'h040;
	localparam logic [11:0] A_OEN_SUPPLY = 12'h041;
	localparam logic [11:0] A_FLAGS_MAIN = 12'h042;
	localparam logic [11:0] A_FLAGS_SUPPLY = 12'h043;
	localparam logic [11:0] A_PATTERN_COUNT = 12'h044;
	localparam logic [11:0] A_CONTROL = 12'h045;
	localparam logic [11:0] A_FRAME_COUNT = 12'h046;
	localparam logic [11:0] A_FRAME_LIMIT = 12'h047;
	localparam logic [11:0] A_CORR_CLEAR = 12'h048;
	localparam logic [11:0] A_MASK_OEN = 12'h049;
	localparam logic [11:0] A_MASK_FLAGS = 12'h04A;
	localparam logic [11:0] A_UNCORR_COUNT = 12'h04B;
	localparam logic [11:0] A_UNCORR_LIMIT = 12'h04C;
	localparam logic [11:0] A_CORR_COUNT = 12'h04D;
	localparam logic [11:0] A_CORR_LIMIT = 12'h04E;
	localparam logic [11:0] A_ADC_SOURCE = 12'h050;
	localparam logic [11:0] A_CAMERA_SOURCE = 12'h051;
	localparam logic [11:0] A_INJ_INTERVAL = 12'h052;
	localparam logic [11:0] A_INJ_BURST = 12'h053;
	localparam logic [11:0] A_FRAME_WINDOW = 12'h054;
	localparam logic [11:0] A_MASK_LATCH_CLEAR = 12'h8C7;
	localparam logic [11:0] A_PIPE0_STATUS = 12'h934;
	localparam logic [11:0] A_PIPE1_STATUS = 12'h974;
	localparam logic [11:0] A_PIPE2_STATUS = 12'h9B4;
	localparam logic [11:0] A_PIPE3_STATUS = 12'h9F4;

	// ************************************************
	// field positions
	// ************************************************
	localparam int F_SEQ = 0;
	localparam int F_BLK = 1;
	localparam int F_PATTERN = 2;
	localparam int F_FRAME = 3;
	localparam int F_CORR = 4;
	localparam int F_ADC = 5;
	localparam int F_CAMERA = 6;
	localparam int F_MEM = 7;
	localparam int F_CMP = 0;
	localparam int F_BROWN = 1;
	localparam int F_POWERUP = 2;
	localparam int F_OVER = 3;
	localparam int F_RETAIN = 4;
	localparam int F_FUSE = 5;
	localparam int C_PATTERN_ON = 0;
	localparam int C_INJ_ON = 1;
	localparam int C_INJ_BURST = 2;
	localparam int C_SYNC_AGG = 3;
	localparam int K_ALL = 0;
	localparam int K_UNCORR = 1;
	localparam int K_CORR = 2;

	// ************************************************
	// reset values and constants
	// ************************************************
	localparam logic [7:0] RV_ZERO = 8'h00;
	localparam logic [7:0] RV_FRAME_WINDOW = 8'h10;
	localparam logic [7:0] RV_INJ_INTERVAL = 8'h40;
	localparam logic [7:0] RV_INJ_BURST = 8'h04;
	localparam logic [7:0] COUNT_MAX = 8'hFF;
	localparam logic [15:0] CRC_POLY = 16'h8005;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;

	typedef enum logic [1:0] {
		FUSE_IDLE = 2'b00,
		FUSE_READ = 2'b01,
		FUSE_CHECK = 2'b11,
		FUSE_DONE = 2'b10
	} fuse_state_t;
endpackage : fault_pkg

// ### verilog/inj_if.sv
`timescale 1ns/1ps
interface inj_if;
	logic enable;
	logic burst;
	logic [7:0] burst_len;
	logic [7:0] interval;
	logic inject;
	modport ctl (output enable, output burst, output burst_len, output interval, input inject);
	modport gen (input enable, input burst, input burst_len, input interval, output inject);
endinterface : inj_if

// ### verilog/fault_injector.sv
`timescale 1ns/1ps
module fault_injector (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control and pulse
	inj_if.gen bus
);
	import fault_pkg::*;

	logic [7:0] gap_q;
	logic [7:0] left_q;
	logic inject_q;

	// gap counts idle bits, left counts remaining corrupted bits
	always_ff @(posedge clk) begin
		if (rst || !bus.enable) begin
			gap_q <= RV_ZERO;
			left_q <= RV_ZERO;
			inject_q <= 1'b0;
		end else if (left_q != RV_ZERO) begin
			inject_q <= 1'b1;
			left_q <= left_q - 8'h01;
		end else begin
			inject_q <= 1'b0;
			if (gap_q >= bus.interval) begin
				gap_q <= RV_ZERO;
				// zero burst length still flips one bit
				left_q <= (bus.burst && bus.burst_len != RV_ZERO) ? bus.burst_len : 8'h01;
			end else begin
				gap_q <= gap_q + 8'h01;
			end
		end
	end

	assign bus.inject = inject_q;
endmodule : fault_injector

// ### verilog/link_error_flag_aggregator.sv
`timescale 1ns/1ps
module link_error_flag_aggregator (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// register port
	input wire logic [fault_pkg::ADDR_W-1:0] ADDR,
	input wire logic [fault_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [fault_pkg::DATA_W-1:0] RDATA,
	// video receive events
	input wire logic VIDEO_SEQUENCE_SLIP,
	input wire logic VIDEO_BLOCK_LENGTH_BAD,
	input wire logic PATTERN_MISMATCH,
	input wire logic [3:0] PIPE_LOCK,
	input wire logic [3:0] VSYNC,
	// correction decoder events
	input wire logic UNCORRECTABLE_BLOCK,
	input wire logic CORRECTED_BIT,
	// monitor events
	input wire logic [7:0] ADC_LIMIT_HIT,
	input wire logic [7:0] CAMERA_RX_FAULT,
	input wire logic MEMORY_FAULT,
	input wire logic SLEEP_EXIT,
	input wire logic RETAINED_CRC_BAD,
	input wire logic LINK_LOCKED,
	// analog supply indications
	input wire logic SUPPLY_CMP_LOW,
	input wire logic CORE_SUPPLY_LOW,
	input wire logic ANALOG_SUPPLY_LOW,
	input wire logic POWERUP_SUPPLY_LOW,
	input wire logic SUPPLY_OVER,
	// fuse array
	output logic [fault_pkg::FUSE_AW-1:0] FUSE_ADDR,
	input wire logic [7:0] FUSE_DATA,
	// outgoing link bit
	input wire logic LINK_TX_IN,
	output logic LINK_TX_OUT,
	// error pin
	output logic ERROR_OUT_N
);
	import fault_pkg::*;

	// ************************************************
	// helpers
	// ************************************************
	function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] set, input logic [7:0] clr);
		sticky = set | (cur & ~clr);
	endfunction : sticky

	// a new event in the clearing cycle restarts at one, not zero
	function automatic logic [7:0] count_next(input logic [7:0] cur, input logic inc, input logic clr);
		if (clr) begin
			count_next = inc ? 8'h01 : RV_ZERO;
		end else if (inc && cur != COUNT_MAX) begin
			count_next = cur + 8'h01;
		end else begin
			count_next = cur;
		end
	endfunction : count_next

	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc;
		for (int i = 7; i >= 0; i--) begin
			c = (c[15] ^ data[i]) ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
		end
		crc_step = c;
	endfunction : crc_step

	// ************************************************
	// bus decode
	// ************************************************
	logic wr_oen_main, wr_oen_supply, wr_control, wr_frame_limit, wr_corr_clear, wr_mask_oen;
	logic wr_uncorr_limit, wr_corr_limit, wr_inj_interval, wr_inj_burst, wr_frame_window, wr_mask_clear;
	logic rd_flags_main, rd_flags_supply, rd_pattern, rd_frame, rd_adc, rd_camera;

	assign wr_oen_main = WR && ADDR == A_OEN_MAIN;
	assign wr_oen_supply = WR && ADDR == A_OEN_SUPPLY;
	assign wr_control = WR && ADDR == A_CONTROL;
	assign wr_frame_limit = WR && ADDR == A_FRAME_LIMIT;
	assign wr_corr_clear = WR && ADDR == A_CORR_CLEAR;
	assign wr_mask_oen = WR && ADDR == A_MASK_OEN;
	assign wr_uncorr_limit = WR && ADDR == A_UNCORR_LIMIT;
	assign wr_corr_limit = WR && ADDR == A_CORR_LIMIT;
	assign wr_inj_interval = WR && ADDR == A_INJ_INTERVAL;
	assign wr_inj_burst = WR && ADDR == A_INJ_BURST;
	assign wr_frame_window = WR && ADDR == A_FRAME_WINDOW;
	assign wr_mask_clear = WR && ADDR == A_MASK_LATCH_CLEAR;
	assign rd_flags_main = RD && ADDR == A_FLAGS_MAIN;
	assign rd_flags_supply = RD && ADDR == A_FLAGS_SUPPLY;
	assign rd_pattern = RD && ADDR == A_PATTERN_COUNT;
	assign rd_frame = RD && ADDR == A_FRAME_COUNT;
	assign rd_adc = RD && ADDR == A_ADC_SOURCE;
	assign rd_camera = RD && ADDR == A_CAMERA_SOURCE;

	// ************************************************
	// configuration registers
	// ************************************************
	logic [7:0] oen_main_q, oen_supply_q, control_q, frame_limit_q, mask_oen_q;
	logic [7:0] uncorr_limit_q, corr_limit_q, inj_interval_q, inj_burst_q, frame_window_q;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			oen_main_q <= RV_ZERO;
			oen_supply_q <= RV_ZERO;
			control_q <= RV_ZERO;
			frame_limit_q <= RV_ZERO;
			mask_oen_q <= RV_ZERO;
			uncorr_limit_q <= RV_ZERO;
			corr_limit_q <= RV_ZERO;
			inj_interval_q <= RV_INJ_INTERVAL;
			inj_burst_q <= RV_INJ_BURST;
			frame_window_q <= RV_FRAME_WINDOW;
		end else begin
			if (wr_oen_main) oen_main_q <= WDATA;
			if (wr_oen_supply) oen_supply_q <= {2'b00, WDATA[5:0]};
			if (wr_control) control_q <= {4'h0, WDATA[3:0]};
			if (wr_frame_limit) frame_limit_q <= WDATA;
			if (wr_mask_oen) mask_oen_q <= {4'h0, WDATA[3:0]};
			if (wr_uncorr_limit) uncorr_limit_q <= WDATA;
			if (wr_corr_limit) corr_limit_q <= WDATA;
			if (wr_inj_interval) inj_interval_q <= WDATA;
			if (wr_inj_burst) inj_burst_q <= WDATA;
			if (wr_frame_window) frame_window_q <= WDATA;
		end
	end

	// ************************************************
	// supply indication synchroniser
	// ************************************************
	logic [4:0] supply_meta_q, supply_q;

	// analog comparators are asynchronous to the reference clock
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			supply_meta_q <= 5'h00;
			supply_q <= 5'h00;
		end else begin
			supply_meta_q <= {SUPPLY_OVER, POWERUP_SUPPLY_LOW, ANALOG_SUPPLY_LOW, CORE_SUPPLY_LOW, SUPPLY_CMP_LOW};
			supply_q <= supply_meta_q;
		end
	end

	// ************************************************
	// video masking
	// ************************************************
	logic [3:0] masked_live, masked_latch_q;

	// all four unlocked means no output at all, so nothing is masked
	assign masked_live = control_q[C_SYNC_AGG] ? (~PIPE_LOCK & {4{|PIPE_LOCK}}) : 4'h0;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			masked_latch_q <= 4'h0;
		end else begin
			masked_latch_q <= masked_live | (masked_latch_q & {4{~wr_mask_clear}});
		end
	end

	// ************************************************
	// frame align window
	// ************************************************
	logic [3:0] vsync_prev_q, vsync_seen_q, vsync_rise;
	logic [7:0] window_left_q;
	logic window_open_q, frame_miss;

	assign vsync_rise = VSYNC & ~vsync_prev_q;
	assign frame_miss = window_open_q && window_left_q == RV_ZERO && (vsync_seen_q | vsync_rise) != 4'hF;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			vsync_prev_q <= 4'h0;
			vsync_seen_q <= 4'h0;
			window_left_q <= RV_ZERO;
			window_open_q <= 1'b0;
		end else begin
			vsync_prev_q <= VSYNC;
			if (!window_open_q) begin
				if (vsync_rise != 4'h0) begin
					window_open_q <= 1'b1;
					window_left_q <= frame_window_q;
					vsync_seen_q <= vsync_rise;
				end
			end else if (window_left_q == RV_ZERO) begin
				window_open_q <= 1'b0;
				vsync_seen_q <= 4'h0;
			end else begin
				window_left_q <= window_left_q - 8'h01;
				vsync_seen_q <= vsync_seen_q | vsync_rise;
			end
		end
	end

	// ************************************************
	// counters
	// ************************************************
	logic [7:0] pattern_count_q, frame_count_q, uncorr_count_q, corr_count_q;
	logic clr_uncorr, clr_corr;

	assign clr_uncorr = wr_corr_clear && (WDATA[K_ALL] || WDATA[K_UNCORR]);
	assign clr_corr = wr_corr_clear && (WDATA[K_ALL] || WDATA[K_CORR]);

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			pattern_count_q <= RV_ZERO;
			frame_count_q <= RV_ZERO;
			uncorr_count_q <= RV_ZERO;
			corr_count_q <= RV_ZERO;
		end else begin
			pattern_count_q <= count_next(pattern_count_q, PATTERN_MISMATCH && control_q[C_PATTERN_ON], rd_pattern);
			frame_count_q <= count_next(frame_count_q, frame_miss, rd_frame);
			uncorr_count_q <= count_next(uncorr_count_q, UNCORRECTABLE_BLOCK, clr_uncorr);
			corr_count_q <= count_next(corr_count_q, CORRECTED_BIT, clr_corr);
		end
	end

	// ************************************************
	// latched sources and flags
	// ************************************************
	logic [7:0] adc_src_q, camera_src_q, sticky_main_q, sticky_supply_q;
	logic [7:0] main_set, supply_set, flags_main, flags_supply;
	logic powerup_phase_q, fuse_fail;

	assign main_set = {MEMORY_FAULT, 5'h00, VIDEO_BLOCK_LENGTH_BAD, VIDEO_SEQUENCE_SLIP};
	assign supply_set = {2'b00,
		1'b0,
		SLEEP_EXIT && RETAINED_CRC_BAD,
		supply_q[4] && LINK_LOCKED,
		supply_q[3] && powerup_phase_q,
		supply_q[1] || supply_q[2],
		supply_q[0]};

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			adc_src_q <= RV_ZERO;
			camera_src_q <= RV_ZERO;
			sticky_main_q <= RV_ZERO;
			sticky_supply_q <= RV_ZERO;
		end else begin
			adc_src_q <= sticky(adc_src_q, ADC_LIMIT_HIT, {8{rd_adc}});
			camera_src_q <= sticky(camera_src_q, CAMERA_RX_FAULT, {8{rd_camera}});
			sticky_main_q <= sticky(sticky_main_q, main_set, {8{rd_flags_main}});
			sticky_supply_q <= sticky(sticky_supply_q, supply_set | {2'b00, fuse_fail, 5'h00},
				{8{rd_flags_supply}});
		end
	end

	always_comb begin
		flags_main = sticky_main_q;
		flags_main[F_PATTERN] = control_q[C_PATTERN_ON] && pattern_count_q != RV_ZERO;
		flags_main[F_FRAME] = frame_count_q > frame_limit_q;
		flags_main[F_CORR] = uncorr_count_q > uncorr_limit_q || corr_count_q > corr_limit_q;
		flags_main[F_ADC] = |adc_src_q;
		flags_main[F_CAMERA] = |camera_src_q;
		flags_supply = sticky_supply_q;
	end

	// ************************************************
	// fuse signature check
	// ************************************************
	fuse_state_t fuse_state_q;
	logic [FUSE_AW-1:0] fuse_addr_q, data_idx_q;
	logic data_valid_q;
	logic [15:0] crc_q, sig_q;

	// signature low byte lands on the first check cycle, so compare only on the second
	assign fuse_fail = fuse_state_q == FUSE_CHECK && !data_valid_q && crc_q != sig_q;

	// read data of the array lag the address by one cycle
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			fuse_state_q <= FUSE_IDLE;
			fuse_addr_q <= '0;
			data_idx_q <= '0;
			data_valid_q <= 1'b0;
			crc_q <= CRC_INIT;
			sig_q <= 16'h0000;
		end else begin
			data_valid_q <= fuse_state_q == FUSE_READ;
			data_idx_q <= fuse_addr_q;
			if (data_valid_q) begin
				if (data_idx_q == FUSE_AW'(FUSE_DEPTH - 2)) begin
					sig_q[15:8] <= FUSE_DATA;
				end else if (data_idx_q == FUSE_AW'(FUSE_DEPTH - 1)) begin
					sig_q[7:0] <= FUSE_DATA;
				end else begin
					crc_q <= crc_step(crc_q, FUSE_DATA);
				end
			end
			case (fuse_state_q)
				FUSE_IDLE: begin
					fuse_state_q <= FUSE_READ;
				end
				FUSE_READ: begin
					if (fuse_addr_q == FUSE_AW'(FUSE_DEPTH - 1)) begin
						fuse_state_q <= FUSE_CHECK;
					end else begin
						fuse_addr_q <= fuse_addr_q + 1'b1;
					end
				end
				FUSE_CHECK: begin
					// wait out the last data beat before comparing
					if (!data_valid_q) fuse_state_q <= FUSE_DONE;
				end
				FUSE_DONE: begin
					fuse_state_q <= FUSE_DONE;
				end
				default: begin
					fuse_state_q <= FUSE_IDLE;
				end
			endcase
		end
	end

	// power-up window ends when the fuse check is finished
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			powerup_phase_q <= 1'b1;
		end else if (fuse_state_q == FUSE_DONE) begin
			powerup_phase_q <= 1'b0;
		end
	end

	// ************************************************
	// fault injector and link bit
	// ************************************************
	inj_if inj ();
	logic link_tx_q;

	assign inj.enable = control_q[C_INJ_ON];
	assign inj.burst = control_q[C_INJ_BURST];
	assign inj.burst_len = inj_burst_q;
	assign inj.interval = inj_interval_q;

	fault_injector u_injector (
		.clk(REF_CLK),
		.rst(RST),
		.bus(inj.gen)
	);

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			link_tx_q <= 1'b0;
		end else begin
			link_tx_q <= LINK_TX_IN ^ inj.inject;
		end
	end

	// ************************************************
	// error pin and read data
	// ************************************************
	logic error_n_q;
	logic [7:0] rdata_q, rd_value;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			error_n_q <= 1'b1;
		end else begin
			error_n_q <= ~(|(flags_main & oen_main_q) || |(flags_supply & oen_supply_q)
				|| |(masked_live & mask_oen_q[3:0]));
		end
	end

	always_comb begin
		case (ADDR)
			A_OEN_MAIN: rd_value = oen_main_q;
			A_OEN_SUPPLY: rd_value = oen_supply_q;
			A_FLAGS_MAIN: rd_value = flags_main;
			A_FLAGS_SUPPLY: rd_value = flags_supply;
			A_PATTERN_COUNT: rd_value = pattern_count_q;
			A_CONTROL: rd_value = control_q;
			A_FRAME_COUNT: rd_value = frame_count_q;
			A_FRAME_LIMIT: rd_value = frame_limit_q;
			A_MASK_OEN: rd_value = mask_oen_q;
			A_MASK_FLAGS: rd_value = {4'h0, masked_live};
			A_UNCORR_COUNT: rd_value = uncorr_count_q;
			A_UNCORR_LIMIT: rd_value = uncorr_limit_q;
			A_CORR_COUNT: rd_value = corr_count_q;
			A_CORR_LIMIT: rd_value = corr_limit_q;
			A_ADC_SOURCE: rd_value = adc_src_q;
			A_CAMERA_SOURCE: rd_value = camera_src_q;
			A_INJ_INTERVAL: rd_value = inj_interval_q;
			A_INJ_BURST: rd_value = inj_burst_q;
			A_FRAME_WINDOW: rd_value = frame_window_q;
			A_PIPE0_STATUS: rd_value = {6'h00, masked_live[0], masked_live[0] | masked_latch_q[0]};
			A_PIPE1_STATUS: rd_value = {6'h00, masked_live[1], masked_live[1] | masked_latch_q[1]};
			A_PIPE2_STATUS: rd_value = {6'h00, masked_live[2], masked_live[2] | masked_latch_q[2]};
			A_PIPE3_STATUS: rd_value = {6'h00, masked_live[3], masked_live[3] | masked_latch_q[3]};
			default: rd_value = RV_ZERO;
		endcase
	end

	// read data stand in each cycle after a cycle with RD high, as long as RD is held, zero otherwise
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			rdata_q <= RV_ZERO;
		end else begin
			rdata_q <= RD ? rd_value : RV_ZERO;
		end
	end

	assign RDATA = rdata_q;
	assign ERROR_OUT_N = error_n_q;
	assign LINK_TX_OUT = link_tx_q;
	assign FUSE_ADDR = fuse_addr_q;
endmodule : link_error_flag_aggregator

// ### testbench/fuse_rom_model.sv
`timescale 1ns/1ps
module fuse_rom_model (
	// clock
	input wire logic clk,
	// array port
	input wire logic [fault_pkg::FUSE_AW-1:0] addr,
	input wire logic bad,
	output logic [7:0] data
);
	import fault_pkg::*;
	logic [7:0] mem [FUSE_DEPTH];
	logic [15:0] crc;
	// ****
	// contents and signature
	// ****
	initial begin
		crc = CRC_INIT;
		for (int i = 0; i < FUSE_DEPTH - 2; i++) begin
			mem[i] = 8'(i * 37 + 5);
			for (int b = 7; b >= 0; b--) begin
				crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ mem[i][b]) ? CRC_POLY : 16'h0000);
			end
		end
		mem[FUSE_DEPTH - 2] = crc[15:8];
		mem[FUSE_DEPTH - 1] = crc[7:0];
	end
	// one-cycle read; bad spoils the low signature byte
	always_ff @(posedge clk) data <= mem[addr] ^ {7'h00, bad && addr == 5'h1F};
endmodule : fuse_rom_model

// ### testbench/err_chk_properties.sv
`timescale 1ns/1ps
module err_chk (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// register port
	input wire logic [fault_pkg::ADDR_W-1:0] ADDR,
	input wire logic [fault_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [fault_pkg::DATA_W-1:0] RDATA,
	// watched pins
	input wire logic VIDEO_SEQUENCE_SLIP,
	input wire logic [fault_pkg::FUSE_AW-1:0] FUSE_ADDR,
	input wire logic LINK_TX_IN,
	input wire logic LINK_TX_OUT,
	input wire logic ERROR_OUT_N
);
	import fault_pkg::*;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// ****
	// enable shadows, rebuilt from bus writes
	// ****
	logic [8:0] oen_q;
	logic [3:0] moen_q;
	logic inj_q;
	wire quiet = ~|{oen_q, moen_q};
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			oen_q <= 9'h000;
			moen_q <= 4'h0;
			inj_q <= 1'b0;
		end else if (WR) begin
			if (ADDR == A_OEN_MAIN) oen_q[7:0] <= WDATA;
			if (ADDR == A_OEN_SUPPLY) oen_q[8] <= |WDATA[5:0];
			if (ADDR == A_MASK_OEN) moen_q <= WDATA[3:0];
			if (ADDR == A_CONTROL) inj_q <= WDATA[C_INJ_ON];
		end
	end
	chk_reset_quiet: assert property (disable iff (1'b0) RST |=> ERROR_OUT_N && RDATA == 8'h00)
		else $error("pin or data active after reset");
	chk_fuse_start: assert property ($fell(RST) |-> ##[1:4] FUSE_ADDR == 5'h01)
		else $error("fuse scan did not start");
	chk_fuse_walk: assert property (FUSE_ADDR != 5'h00 && FUSE_ADDR != 5'h1F
		|=> FUSE_ADDR == $past(FUSE_ADDR) + 5'h01)
		else $error("fuse address skipped");
	chk_seq_pin: assert property (VIDEO_SEQUENCE_SLIP && oen_q[F_SEQ] |-> ##2 !ERROR_OUT_N)
		else $error("pin missed sequence slip");
	chk_pin_quiet: assert property (quiet && $past(quiet) |-> ERROR_OUT_N)
		else $error("pin low with no enable");
	chk_mask_read: assert property (RD && ADDR == A_MASK_OEN |=> RDATA[3:0] == moen_q)
		else $error("mask enable readback wrong");
	chk_seq_clear: assert property (RD && ADDR == A_FLAGS_MAIN && !VIDEO_SEQUENCE_SLIP ##1
		RD && ADDR == A_FLAGS_MAIN |=> !RDATA[F_SEQ])
		else $error("slip flag survived its read");
	chk_inject_off: assert property (!inj_q && !$past(inj_q) && !$past(inj_q, 2)
		|=> LINK_TX_OUT == $past(LINK_TX_IN))
		else $error("link bit altered while idle");
	cover property ($fell(ERROR_OUT_N));
	cover property (inj_q && LINK_TX_OUT != $past(LINK_TX_IN));
	cover property (WR && ADDR == A_MASK_LATCH_CLEAR);
endmodule : err_chk
bind link_error_flag_aggregator err_chk u_chk (.*);

// ### testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(g, x) begin \
	num_checks++; \
	if ((g) !== (x)) begin \
		bad_count++; \
		$display("[FAIL] %0t mismatch got %h want %h", $time, g, x); \
	end \
end
module testbench;
	import fault_pkg::*;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, locked = 1'b1, crc_bad = 1'b0, tx = 1'b0, bad = 1'b0;
	logic t, err_n, tx_out;
	logic [11:0] addr = 12'h000;
	logic [7:0] wdata = 8'h00, adc = 8'h00, cam = 8'h00, rdata, fdata;
	logic [7:0] se[5] = '{8'h01, 8'h02, 8'h02, 8'h08, 8'h00};
	logic [11:0] ra[5] = '{A_OEN_MAIN, A_OEN_SUPPLY, A_FRAME_WINDOW, A_FLAGS_SUPPLY, 12'h7FF};
	logic [7:0] rv[5] = '{8'h00, 8'h00, RV_FRAME_WINDOW, 8'h00, 8'h00};
	logic [6:0] ev = 7'h00;
	logic [4:0] sup = 5'h00, faddr;
	logic [3:0] lock = 4'hF, vs = 4'h0;
	int bad_count = 0, num_checks = 0, k, fl;
	initial forever #50 clk = ~clk;
	link_error_flag_aggregator u_dut (.REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .VIDEO_SEQUENCE_SLIP(ev[0]), .VIDEO_BLOCK_LENGTH_BAD(ev[1]), .PATTERN_MISMATCH(ev[2]),
		.PIPE_LOCK(lock), .VSYNC(vs), .UNCORRECTABLE_BLOCK(ev[3]), .CORRECTED_BIT(ev[4]), .ADC_LIMIT_HIT(adc),
		.CAMERA_RX_FAULT(cam), .MEMORY_FAULT(ev[5]), .SLEEP_EXIT(ev[6]), .RETAINED_CRC_BAD(crc_bad),
		.LINK_LOCKED(locked), .SUPPLY_CMP_LOW(sup[0]), .CORE_SUPPLY_LOW(sup[1]), .ANALOG_SUPPLY_LOW(sup[2]),
		.SUPPLY_OVER(sup[3]), .POWERUP_SUPPLY_LOW(sup[4]), .FUSE_ADDR(faddr), .FUSE_DATA(fdata),
		.LINK_TX_IN(tx), .LINK_TX_OUT(tx_out), .ERROR_OUT_N(err_n));
	fuse_rom_model u_fuse (.clk(clk), .addr(faddr), .bad(bad), .data(fdata));
	// ****
	// bus and stimulus tasks
	// ****
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask : w
	task automatic wrt(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wrt
	// n reads back to back, only the last one compared
	task automatic rdc(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m, input int n);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		repeat (n) @(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(rdata & m, e & m)
	endtask : rdc
	task automatic pl(input int i, input int n);
		repeat (n) begin
			@(posedge clk);
			ev[i] <= 1'b1;
			@(posedge clk);
			ev[i] <= 1'b0;
		end
	endtask : pl
	function automatic int flips(input int n);
		return 42 * n / (n + 3);
	endfunction : flips
	task automatic conclude;
		if (bad_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude
	// ****
	// scenarios
	// ****
	initial begin
		void'($urandom(32'h2F97));
		w(3);
		rst <= 1'b0;
		w(45);
		foreach (ra[i]) rdc(ra[i], rv[i], 8'hFF, 1);
		wrt(A_OEN_MAIN, 8'h01);
		pl(1, 1);
		w(3);
		`CHK(err_n, 1'b1)
		pl(0, 1);
		w(2);
		`CHK(err_n, 1'b0)
		rdc(A_FLAGS_MAIN, 8'h03, 8'hFF, 1);
		rdc(A_FLAGS_MAIN, 8'h00, 8'hFF, 1);
		`CHK(err_n, 1'b1)
		pl(0, 1);
		rdc(A_FLAGS_MAIN, 8'h00, 8'h01, 2);
		wrt(A_CONTROL, 8'h01);
		k = $urandom_range(5, 1);
		pl(2, k);
		rdc(A_FLAGS_MAIN, 8'h04, 8'h04, 1);
		rdc(A_PATTERN_COUNT, 8'(k), 8'hFF, 1);
		rdc(A_FLAGS_MAIN, 8'h00, 8'h04, 1);
		for (int c = 0; c < 3; c++) begin
			pl(3, 2);
			pl(4, 2);
			rdc(A_FLAGS_MAIN, 8'h10, 8'h10, 1);
			wrt(A_CORR_CLEAR, 8'h01 << c);
			rdc(A_UNCORR_COUNT, (c == 2) ? 8'h02 : 8'h00, 8'hFF, 1);
			rdc(A_CORR_COUNT, (c == 1) ? 8'h02 : 8'h00, 8'hFF, 1);
			wrt(A_CORR_CLEAR, 8'h01);
		end
		k = $urandom_range(4, 1);
		wrt(A_UNCORR_LIMIT, 8'(k));
		pl(3, k);
		rdc(A_FLAGS_MAIN, 8'h00, 8'h10, 1);
		pl(3, 1);
		rdc(A_FLAGS_MAIN, 8'h10, 8'h10, 1);
		wrt(A_CORR_CLEAR, 8'h01);
		for (int v = 1; v < 3; v++) begin
			@(posedge clk) vs <= (v == 1) ? 4'h1 : 4'hF;
			w(25);
			rdc(A_FLAGS_MAIN, (v == 1) ? 8'h08 : 8'h00, 8'h08, 1);
			rdc(A_FRAME_COUNT, 8'(2 - v), 8'hFF, 1);
			rdc(A_FLAGS_MAIN, 8'h00, 8'h08, 1);
			@(posedge clk) vs <= 4'h0;
		end
		for (int s = 0; s < 2; s++) begin
			k = $urandom_range(255, 1);
			@(posedge clk);
			if (s == 0) adc <= 8'(k);
			else cam <= 8'(k);
			@(posedge clk);
			adc <= 8'h00;
			cam <= 8'h00;
			rdc(A_FLAGS_MAIN, 8'h20 << s, 8'h60, 1);
			rdc(s ? A_CAMERA_SOURCE : A_ADC_SOURCE, 8'(k), 8'hFF, 1);
			rdc(A_FLAGS_MAIN, 8'h00, 8'h60, 1);
		end
		pl(5, 1);
		rdc(A_FLAGS_MAIN, 8'h80, 8'h80, 1);
		rdc(A_FLAGS_MAIN, 8'h00, 8'h80, 1);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			locked <= (i != 4);
			sup[(i == 4) ? 3 : i] <= 1'b1;
			w(4);
			sup <= 5'h00;
			w(4);
			rdc(A_FLAGS_SUPPLY, se[i], 8'hFF, 1);
		end
		@(posedge clk) crc_bad <= 1'b1;
		pl(6, 1);
		rdc(A_FLAGS_SUPPLY, 8'h10, 8'hFF, 1);
		wrt(A_CONTROL, 8'h08);
		lock <= 4'h1;
		w(3);
		rdc(A_MASK_FLAGS, 8'h0E, 8'h0F, 1);
		wrt(A_MASK_OEN, 8'h02);
		w(2);
		`CHK(err_n, 1'b0)
		rdc(A_MASK_OEN, 8'h02, 8'hFF, 1);
		lock <= 4'hF;
		w(3);
		rdc(A_PIPE1_STATUS, 8'h01, 8'h03, 1);
		wrt(A_MASK_LATCH_CLEAR, 8'h01);
		rdc(A_PIPE1_STATUS, 8'h00, 8'h03, 1);
		wrt(A_MASK_OEN, 8'h00);
		wrt(A_INJ_INTERVAL, 8'h02);
		for (int b = 0; b < 2; b++) begin
			wrt(A_CONTROL, b ? 8'h06 : 8'h02);
			fl = 0;
			repeat (42) begin
				@(posedge clk);
				t = tx;
				tx <= 1'($urandom);
				#1;
				fl += int'(tx_out !== t);
			end
			`CHK(fl > flips(b * 3 + 1) - 5 && fl < flips(b * 3 + 1) + 5, 1'b1)
		end
		wrt(A_CONTROL, 8'h00);
		bad <= 1'b1;
		sup[4] <= 1'b1;
		rst <= 1'b1;
		w(3);
		rst <= 1'b0;
		w(45);
		sup[4] <= 1'b0;
		rdc(A_FLAGS_SUPPLY, 8'h24, 8'hFF, 1);
		rdc(A_FLAGS_SUPPLY, 8'h00, 8'hFF, 1);
		conclude();
	end
	// whole sequence needs under 2000 cycles
	initial begin
		w(20000);
		bad_count++;
		conclude();
	end
endmodule : testbench
